// ==== bench/ulm_frontend_monitor.sv ====
// Port checker for the line-mode front end
module ulm_frontend_monitor
    import ulm_pkg::*;
(
    // Clock, reset, bus
    input wire logic        core_clk, srst, clk_en, hsel, hready, hwrite,
    input wire logic [1:0]  htrans,
    input wire logic [31:0] haddr, hwdata,
    // Core side
    input wire logic        baud_x16_tick, core_tx, core_rx, tsr_empty, fifo_empty, fifo_write,
    input wire logic        stop_bit_next, modem_dtr, tx_irq,
    input wire logic        rx_store_en, rx_thr_irq_en, rx_err_irq_en, rx_tmo_irq_en,
    // Line side
    input wire logic        rx_pin, tx_pin, line_driver_enable_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       wp;
    logic       lp;
    logic [7:0] wa;
    logic [7:0] alternate_function_ctrl;
    logic [2:0] pw;
    wire        hdx = alternate_function_ctrl[ULM_AFR_HDX];
    wire        ir  = alternate_function_ctrl[ULM_AFR_INFRARED_ENABLE];
    wire        lg  = alternate_function_ctrl[ULM_AFR_LG];
    wire        ls  = alternate_function_ctrl[ULM_AFR_LISTEN];
    wire        de  = line_driver_enable_out;
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the control registers, seen from the bus
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wp  <= 1'b0;
            wa  <= 8'h00;
            alternate_function_ctrl <= ULM_AFR_RESET;
            lp  <= 1'b0;
            pw  <= 3'h0;
        end else if (clk_en) begin
            wp <= hsel && hready && htrans == ULM_HTRANS_NSEQ && hwrite;
            wa <= haddr[7:0];
            if (wp && wa == ULM_ADDR_AFR) alternate_function_ctrl <= hwdata[7:0];
            if (wp && wa == ULM_ADDR_CTRL) lp <= hwdata[ULM_CTRL_LOOP];
            // Ticks seen while the pulse is up
            if (!tx_pin || !ir) pw <= 3'h0;
            else if (baud_x16_tick) pw <= pw + 3'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_idle;
        (hdx && alternate_function_ctrl[7:5] == 3'h0 && tsr_empty && fifo_empty && !fifo_write && !stop_bit_next) [*2];
    endsequence
    a_de_bypass: assert property (!hdx |-> de == modem_dtr) else $error("enable not modem level");
    a_de_rise: assert property (hdx && stop_bit_next |=> !hdx || de) else $error("enable not raised");
    a_de_hold: assert property (hdx && de && !(tsr_empty && fifo_empty) |=> !hdx || de)
        else $error("enable dropped early");
    a_de_zero: assert property (s_idle |-> !de) else $error("enable held with zero delay");
    a_irq_shift: assert property (hdx && !lg && $rose(tsr_empty) |-> ##[1:3] tx_irq)
        else $error("no irq on shifter empty");
    a_irq_hold: assert property (hdx && !lg && !tsr_empty && !$past(tsr_empty) |-> !tx_irq)
        else $error("irq while shifting");
    a_rx_gate: assert property ((hdx || ir) && !ls && !lp |-> !rx_store_en && !rx_thr_irq_en && !rx_err_irq_en)
        else $error("receive not gated");
    a_tmo_listen: assert property (!ls |-> !rx_tmo_irq_en) else $error("timeout without listen");
    a_rx_bypass: assert property (!ir && !lp |-> core_rx == rx_pin) else $error("receive not bypassed");
    a_ir_idle: assert property ((ir && !lp && core_tx) [*3] |-> !tx_pin) else $error("pulse on high data");
    a_ir_width: assert property (ir && $past(ir) && $fell(tx_pin) |-> pw == ULM_PULSE_CYC)
        else $error("pulse width off");
endmodule
bind ulm_frontend ulm_frontend_monitor u_mon (.core_clk, .srst, .clk_en, .hsel, .hready, .hwrite, .htrans, .haddr,
    .hwdata, .baud_x16_tick, .core_tx, .core_rx, .tsr_empty, .fifo_empty, .fifo_write, .stop_bit_next,
    .modem_dtr, .tx_irq, .rx_store_en, .rx_thr_irq_en, .rx_err_irq_en, .rx_tmo_irq_en, .rx_pin, .tx_pin,
    .line_driver_enable_out);

// ==== bench/ulm_frontend_tb_top.sv ====
// Bench for the line-mode front end
module ulm_frontend_tb_top
    import ulm_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 0, srst = 1, hsel = 0, hwrite = 0, baud_x16_tick = 0, core_tx = 1, modem_dtr = 0;
    logic        tsr_empty = 1, fifo_empty = 1, fifo_write = 0, fifo_over_thr = 0, stop_bit_next = 0;
    logic        ir_m = 0, pos = 0, zero = 0, txp = 0, clk_en = 1;
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, core_rx, rx_store_en, rx_thr_irq_en, rx_err_irq_en, rx_tmo_irq_en;
    logic        tx_irq, rx_pin, tx_pin, de, rx_sample;
    logic [7:0]  modes [6] = '{8'h10, 8'h14, 8'h12, 8'h00, 8'h04, 8'h02};
    int          error_cnt = 0, checks = 0, cyc = 0, irqs = 0, rises = 0, smps = 0;
    ulm_frontend uut (.core_clk, .srst, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .baud_x16_tick, .core_tx, .core_rx, .tsr_empty,
        .fifo_empty, .fifo_write, .fifo_over_thr, .stop_bit_next, .modem_dtr, .rx_store_en, .rx_sample,
        .rx_thr_irq_en, .rx_err_irq_en, .rx_tmo_irq_en, .tx_irq, .rx_pin, .tx_pin, .line_driver_enable_out(de));
    ulm_line_model far (.core_clk, .ir_mode(ir_m), .pos_pulse(pos), .send_zero(zero), .rx_pin);
    initial forever #25 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Tick every other cycle; hang guard of about thirteen run lengths
    always @(posedge core_clk) begin
        baud_x16_tick <= !baud_x16_tick;
        cyc++;
        if (tx_irq === 1'b1) irqs++;
        if (tx_pin === 1'b1 && txp === 1'b0) rises++;
        if (rx_sample === 1'b1) smps++;
        txp <= tx_pin;
        if (cyc == 6000) begin
            error_cnt++;
            report_and_stop;
        end
    end
    task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chkw({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Single word transfer, address then data phase
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= ULM_HTRANS_NSEQ;
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic set(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
        wt(1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic st;
        int   n;
        wt(20);
        srst <= 1'b0;
        ahb(1'b0, ULM_ADDR_AFR, 0);
        chkw(rd, {24'h0, ULM_AFR_RESET});
        chkb(hresp, 1'b0);
        ahb(1'b1, 8'h0C, 32'hFF);
        ahb(1'b0, 8'h0C, 0);
        chkw(rd, 32'h0);
        ahb(1'b1, ULM_ADDR_AFR, 32'hFFFF_FFA5);
        ahb(1'b0, ULM_ADDR_AFR, 0);
        chkw(rd, 32'hA5);
        for (int l = 0; l < 2; l++) begin
            set(ULM_ADDR_CTRL, 32'(l));
            foreach (modes[i]) begin
                set(ULM_ADDR_AFR, {24'h0, modes[i]});
                st = l == 1 || modes[i][4] || modes[i][2:1] == 2'h0;
                chkb(rx_store_en, st);
                chkb(rx_thr_irq_en, st);
                chkb(rx_err_irq_en, st);
                chkb(rx_tmo_irq_en, modes[i][4]);
            end
        end
        set(ULM_ADDR_AFR, 32'h0);
        core_tx <= 1'b0;
        wt(2);
        chkb(tx_pin, 1'b1);
        set(ULM_ADDR_CTRL, 32'h0);
        chkb(tx_pin, 1'b0);
        core_tx <= 1'b1;
        modem_dtr <= 1'b1;
        wt(1);
        chkb(de, 1'b1);
        modem_dtr <= 1'b0;
        // Delay of two bit times is 64 cycles at this tick rate
        set(ULM_ADDR_AFR, 32'h44);
        tsr_empty <= 1'b0;
        fifo_empty <= 1'b0;
        stop_bit_next <= 1'b1;
        wt(1);
        stop_bit_next <= 1'b0;
        wt(1);
        chkb(de, 1'b1);
        fifo_empty <= 1'b1;
        wt(10);
        chkb(de, 1'b1);
        tsr_empty <= 1'b1;
        wt(40);
        fifo_write <= 1'b1;
        wt(1);
        fifo_write <= 1'b0;
        wt(56);
        chkb(de, 1'b1);
        wt(16);
        chkb(de, 1'b0);
        n = irqs;
        set(ULM_ADDR_AFR, 32'h04);
        tsr_empty <= 1'b0;
        wt(6);
        tsr_empty <= 1'b1;
        wt(6);
        chkb(de, 1'b0);
        chkw(irqs, n + 1);
        set(ULM_ADDR_AFR, 32'h0C);
        fifo_over_thr <= 1'b1;
        wt(4);
        fifo_over_thr <= 1'b0;
        wt(4);
        fifo_empty <= 1'b0;
        wt(4);
        fifo_empty <= 1'b1;
        wt(4);
        chkw(irqs, n + 3);
        // Frozen core must drop a bus write
        clk_en <= 1'b0;
        ahb(1'b1, ULM_ADDR_AFR, 32'h0);
        clk_en <= 1'b1;
        ahb(1'b0, ULM_ADDR_AFR, 0);
        chkw(rd, 32'h0C);
        // Infrared with listen on
        set(ULM_ADDR_AFR, 32'h12);
        ahb(1'b0, ULM_ADDR_STATUS, 0);
        chkw(rd, 32'h04);
        ir_m <= 1'b1;
        chkb(core_rx, 1'b1);
        n = rises;
        core_tx <= 1'b0;
        wt(66);
        core_tx <= 1'b1;
        chkw(rises, n + 2);
        wt(10);
        chkb(tx_pin, 1'b0);
        n = smps;
        zero <= 1'b1;
        wt(1);
        zero <= 1'b0;
        wt(12);
        chkb(core_rx, 1'b0);
        wt(30);
        chkb(core_rx, 1'b1);
        chkw(smps, n + 1);
        pos <= 1'b1;
        wt(40);
        zero <= 1'b1;
        wt(1);
        zero <= 1'b0;
        wt(3);
        chkb(core_rx, 1'b1);
        wt(12);
        chkb(core_rx, 1'b0);
        wt(34);
        chkb(core_rx, 1'b1);
        report_and_stop;
    end
endmodule

// ==== bench/ulm_line_model.sv ====
// Far-side optics and transceiver: sends one zero bit on request
module ulm_line_model (
    // Control from the bench
    input  wire logic core_clk,
    input  wire logic ir_mode,
    input  wire logic pos_pulse,
    input  wire logic send_zero,
    // Line
    output logic      rx_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int left = 0;
    // Pulse of three 16x ticks in infrared, a whole bit otherwise
    always @(posedge core_clk) begin
        if (send_zero) left <= ir_mode ? 6 : 32;
        else if (left > 0) left <= left - 1;
    end
    // Inverting PIN stage idles high, a non-inverting one idles low
    assign rx_pin = ((left > 0) == pos_pulse);
endmodule

// ==== src/ulm_frontend.sv ====
// Line-mode front end: RS-485 direction, interrupt gating, infrared path
// How it works
// - Bit 1 routes data through infrared codec
// - Bit 2 enables automatic RS-485 driver enable
// - Half-duplex, no large block: hold TX irq
// - Half-duplex without listen: receiver off transmitting
// - Bits 7:5 hold turnaround delay bit times
// - Delay starts when both empty; write aborts
// - Driver enable rises before stop, holds pending
// - Driver enable stays for delay then drops
// - Large block: irq on threshold or empty
// - Half-duplex small block: irq shifter empty
// - Listen set: store data, all irqs
// - Plain mode without listen: no timeout irq
// - Half-duplex/infrared without listen: nothing stored
// - Loopback: pins idle, store, timeout needs listen
// - Infrared frames single bits, any rate
// - Codec runs from 16x clock tick
// - Pulse three 16x clocks wide minimum
// - High transmit keeps output low, clears counter
// - Pulse from tick seven to ten
// - Reset: receive high, counter cleared
// - Falling edge gives sixteen-clock low
// - Receiver samples mid bit, every sixteen
// - Positive pulses decode on trailing edge
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
module ulm_frontend
    import ulm_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        clk_en,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // UART core timing and transmit status
    input  wire logic        baud_x16_tick,
    input  wire logic        core_tx,
    output logic             core_rx,
    input  wire logic        tsr_empty,
    input  wire logic        fifo_empty,
    input  wire logic        fifo_write,
    input  wire logic        fifo_over_thr,
    input  wire logic        stop_bit_next,
    input  wire logic        modem_dtr,
    // Receive gating and transmit interrupt toward the core
    output logic             rx_store_en,
    output logic             rx_sample,
    output logic             rx_thr_irq_en,
    output logic             rx_err_irq_en,
    output logic             rx_tmo_irq_en,
    output logic             tx_irq,
    // Line pins
    input  wire logic        rx_pin,
    output logic             tx_pin,
    output logic             line_driver_enable_out
);
    typedef enum logic [1:0] {ULM_IDLE, ULM_SEND, ULM_HOLD} ulm_de_t;

    typedef struct packed {
        logic [7:0] alternate_function_ctrl;
        logic [1:0] ctrl;
        logic       ph_wr;
        logic       ph_rd;
        logic [7:0] ph_addr;
        logic [31:0] rdata;
        ulm_de_t    de_st;
        logic [3:0] bit_cnt;
        logic [2:0] dly_left;
        logic       de;
        logic       tsr_prev;
        logic       fifo_prev;
        logic       thr_prev;
        logic       txi;
        logic       int_rx_prev;
        logic       smp_run;
        logic [3:0] smp_cnt;
        logic       smp;
    } ulm_state_t;

    ulm_state_t st;
    ulm_state_t next_st;

    logic infrared_enable, hdx, lg, listen, loopb;
    logic codec_tx, int_tx, int_rx, codec_rx;
    logic rx_enable;

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    ////////////////////////////////////////////////////////////////
    assign infrared_enable   = st.alternate_function_ctrl[ULM_AFR_INFRARED_ENABLE];
    assign hdx    = st.alternate_function_ctrl[ULM_AFR_HDX];
    assign lg     = st.alternate_function_ctrl[ULM_AFR_LG];
    assign listen = st.alternate_function_ctrl[ULM_AFR_LISTEN];
    assign loopb  = st.ctrl[ULM_CTRL_LOOP];

    // Loopback keeps pins idle and feeds transmit straight back
    assign int_tx = loopb ? 1'b1 : core_tx;
    assign tx_pin = loopb ? (infrared_enable ? 1'b0 : 1'b1) : (infrared_enable ? codec_tx : core_tx);
    assign codec_rx = infrared_enable ? int_rx : rx_pin;
    assign core_rx  = loopb ? core_tx : codec_rx;

    ulm_ir_codec u_codec (
        .core_clk (core_clk),
        .srst     (srst),
        .clk_en   (clk_en),
        .tick16   (baud_x16_tick),
        .int_tx   (int_tx),
        .int_rx   (int_rx),
        .rx_pin   (loopb ? 1'b1 : rx_pin),
        .ir_tx    (codec_tx)
    );

    ////////////////////////////////////////////////////////////////
    always_comb begin
        rx_enable     = 1'b1;
        rx_tmo_irq_en = listen;
        if (!loopb && !listen && (hdx || infrared_enable)) rx_enable = 1'b0;
        // Loopback data is kept even while sending
        if (!loopb && hdx && !listen && st.de_st == ULM_SEND) rx_enable = 1'b0;
    end
    assign rx_store_en   = rx_enable;
    assign rx_thr_irq_en = rx_enable;
    assign rx_err_irq_en = rx_enable;
    assign rx_sample     = st.smp & rx_enable;
    assign tx_irq        = st.txi;
    assign line_driver_enable_out = hdx ? st.de : modem_dtr;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        // Bus address phase
        next_st.ph_wr = 1'b0;
        next_st.ph_rd = 1'b0;
        if (hsel && hready && htrans == ULM_HTRANS_NSEQ) begin
            next_st.ph_wr   = hwrite;
            next_st.ph_rd   = ~hwrite;
            next_st.ph_addr = haddr[ULM_ADDR_W-1:0];
        end
        // Bus data phase
        if (st.ph_wr) begin
            if (addr_is(st.ph_addr, ULM_ADDR_AFR)) next_st.alternate_function_ctrl = hwdata[7:0];
            if (addr_is(st.ph_addr, ULM_ADDR_CTRL)) next_st.ctrl = hwdata[1:0];
        end
        next_st.rdata = '0;
        if (hsel && hready && htrans == ULM_HTRANS_NSEQ && !hwrite) begin
            if (addr_is(haddr[ULM_ADDR_W-1:0], ULM_ADDR_AFR)) next_st.rdata = {24'h0, st.alternate_function_ctrl};
            else if (addr_is(haddr[ULM_ADDR_W-1:0], ULM_ADDR_CTRL)) next_st.rdata = {30'h0, st.ctrl};
            else if (addr_is(haddr[ULM_ADDR_W-1:0], ULM_ADDR_STATUS))
                next_st.rdata = {24'h0, st.dly_left, st.txi, st.de, rx_enable, st.de_st};
        end

        // Driver-enable sequencing
        next_st.de_st = st.de_st;
        case (st.de_st)
            ULM_IDLE: begin
                next_st.de = 1'b0;
                if (hdx && stop_bit_next) begin
                    next_st.de_st = ULM_SEND;
                    next_st.de    = 1'b1;
                end
            end
            ULM_SEND: begin
                next_st.de = 1'b1;
                if (tsr_empty && fifo_empty) begin
                    next_st.dly_left = st.alternate_function_ctrl[ULM_AFR_DLY_HI:ULM_AFR_DLY_LO];
                    next_st.bit_cnt  = '0;
                    next_st.de_st    = ULM_HOLD;
                    if (st.alternate_function_ctrl[ULM_AFR_DLY_HI:ULM_AFR_DLY_LO] == 3'h0) begin
                        next_st.de_st = ULM_IDLE;
                        next_st.de    = 1'b0;
                    end
                end
            end
            ULM_HOLD: begin
                if (fifo_write || !tsr_empty) begin
                    next_st.de_st = ULM_SEND;
                end else if (baud_x16_tick) begin
                    next_st.bit_cnt = st.bit_cnt + 4'h1;
                    if (st.bit_cnt == ULM_BIT_LAST) begin
                        next_st.dly_left = st.dly_left - 3'h1;
                        if (st.dly_left == 3'h1) begin
                            next_st.de_st = ULM_IDLE;
                            next_st.de    = 1'b0;
                        end
                    end
                end
            end
            default: next_st.de_st = ULM_IDLE;
        endcase
        if (!hdx) begin
            next_st.de_st = ULM_IDLE;
            next_st.de    = 1'b0;
        end

        // Transmit interrupt source
        next_st.tsr_prev  = tsr_empty;
        next_st.fifo_prev = fifo_empty;
        next_st.thr_prev  = fifo_over_thr;
        next_st.txi       = 1'b0;
        if (hdx && !lg) begin
            next_st.txi = tsr_empty & ~st.tsr_prev;
        end else begin
            next_st.txi = (st.thr_prev & ~fifo_over_thr)
                        | (fifo_empty & ~st.fifo_prev & ~st.thr_prev);
        end

        // Mid-bit sample strobe
        next_st.int_rx_prev = core_rx;
        next_st.smp = 1'b0;
        if (!st.smp_run) begin
            if (st.int_rx_prev && !core_rx) begin
                next_st.smp_run = 1'b1;
                next_st.smp_cnt = '0;
            end
        end else if (baud_x16_tick) begin
            next_st.smp_cnt = st.smp_cnt + 4'h1;
            if (st.smp_cnt == ULM_MID_BIT) begin
                next_st.smp = 1'b1;
                if (core_rx) next_st.smp_run = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st       <= '0;
            st.alternate_function_ctrl   <= ULM_AFR_RESET;
            st.de_st <= ULM_IDLE;
            st.tsr_prev  <= 1'b1;
            st.fifo_prev <= 1'b1;
            st.int_rx_prev <= 1'b1;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st.rdata;
endmodule

// ==== src/ulm_ir_codec.sv ====
// Infrared SIR encoder and decoder on the 16x baud tick
module ulm_ir_codec
    import ulm_pkg::*;
(
    // Clock and control
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic clk_en,
    input  wire logic tick16,
    // Internal serial side
    input  wire logic int_tx,
    output logic      int_rx,
    // Line side
    input  wire logic rx_pin,
    output logic      ir_tx
);
    typedef struct packed {
        logic [3:0] enc_cnt;
        logic       enc_out;
        logic [3:0] dec_cnt;
        logic       dec_low;
        logic       rx_prev;
    } ulm_ir_state_t;

    ulm_ir_state_t st;
    ulm_ir_state_t next_st;
    logic          fall;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        fall    = st.rx_prev & ~rx_pin;
        next_st.rx_prev = rx_pin;
        if (int_tx) begin
            next_st.enc_cnt = '0;
            next_st.enc_out = 1'b0;
        end else if (tick16) begin
            next_st.enc_cnt = st.enc_cnt + 4'h1;
            // Pulse ticks 7..9 give three 16x clocks
            if (st.enc_cnt == ULM_IR_RISE) next_st.enc_out = 1'b1;
            if (st.enc_cnt == ULM_IR_FALL) next_st.enc_out = 1'b0;
        end
        // Edge latched even between ticks so short pulses are not missed
        if (fall && !st.dec_low) begin
            next_st.dec_low = 1'b1;
            next_st.dec_cnt = '0;
        end else if (st.dec_low && tick16) begin
            next_st.dec_cnt = st.dec_cnt + 4'h1;
            if (st.dec_cnt == ULM_IR_LAST) next_st.dec_low = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st <= '{enc_cnt: 4'h0, enc_out: 1'b0, dec_cnt: 4'h0, dec_low: 1'b0, rx_prev: 1'b1};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign ir_tx  = st.enc_out;
    assign int_rx = ~st.dec_low;
endmodule

// ==== src/ulm_pkg.sv ====
// Constants shared by the line-mode front end
package ulm_pkg;
    // AHB-Lite map (byte addresses)
    localparam logic [7:0] ULM_ADDR_AFR    = 8'h00;
    localparam logic [7:0] ULM_ADDR_CTRL   = 8'h04;
    localparam logic [7:0] ULM_ADDR_STATUS = 8'h08;
    localparam int         ULM_ADDR_W      = 8;
    // alternate_function_ctrl fields
    localparam int         ULM_AFR_INFRARED_ENABLE    = 1;
    localparam int         ULM_AFR_HDX     = 2;
    localparam int         ULM_AFR_LG      = 3;
    localparam int         ULM_AFR_LISTEN  = 4;
    localparam int         ULM_AFR_DLY_LO  = 5;
    localparam int         ULM_AFR_DLY_HI  = 7;
    localparam logic [7:0] ULM_AFR_RESET   = 8'h00;
    // Extra control register fields
    localparam int         ULM_CTRL_LOOP   = 0;
    localparam int         ULM_CTRL_MDMDE  = 1;
    // Infrared timing in 16x clock ticks
    localparam logic [3:0] ULM_IR_RISE     = 4'h6;
    localparam logic [3:0] ULM_IR_FALL     = 4'h9;
    localparam logic [3:0] ULM_IR_LAST     = 4'hF;
    localparam logic [3:0] ULM_BIT_LAST    = 4'hF;
    localparam logic [3:0] ULM_MID_BIT     = 4'h7;
    localparam int         ULM_OX          = 16;
    localparam int         ULM_PULSE_CYC   = 3;
    localparam real        ULM_PULSE_NS    = 1600.0;
    localparam real        ULM_CLK_NS      = 50.0;
    localparam int         ULM_PULSE_MIN   = int'((ULM_PULSE_NS + ULM_CLK_NS - 1.0) / ULM_CLK_NS);
    localparam logic [1:0] ULM_HTRANS_NSEQ = 2'h2;
endpackage
